//--- logic/tvf_consts.svh
// constants for the type and virtual-memory fault reporting block
// assumes inclusion from the fault unit module
`ifndef TVF_CONSTS_SVH
`define TVF_CONSTS_SVH
`define TVF_TYPE_TYPEFLT 8'h0a
`define TVF_TYPE_VMFLT 8'h06
`define TVF_SUB_MISMATCH 8'h01
`define TVF_SUB_CONTENTS 8'h02
`define TVF_SUB_SEGENT 8'h01
`define TVF_SUB_DIRENT 8'h02
`define TVF_SUB_PAGEENT 8'h03
`define TVF_ADDR_HI_LSB 12
`define TVF_SEGIDX_LSB 5
`define TVF_WRITE_WORDS 3'h5
`endif

//--- logic/tvf_pkg.sv
// types for the fault reporting block
// assumes tvf_consts.svh is on the include path
package tvf_pkg;
  typedef enum logic [1:0] {
    TVF_IDLE = 2'b00,
    TVF_WRITE = 2'b01,
    TVF_DISPATCH = 2'b11
  } tvf_state_t;
endpackage

//--- logic/tvf_record_reg.sv
// fault record storage word, loaded by the sequencer
// assumes same-clock load strobes
`timescale 1ns/1ps
module tvf_record_reg (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic load, // load strobe
  input wire logic [31:0] dIn, // word in
  output logic [31:0] dOut // registered word
);
  logic [31:0] word_reg;
  logic [31:0] word_next;
  // hold or load
  always_comb begin
    word_next = load ? dIn : word_reg;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      word_reg <= 32'h0;
    end else begin
      word_reg <= word_next;
    end
  end
  assign dOut = word_reg;
endmodule // tvf_record_reg

//--- logic/tvf_fault_unit.sv
// fault detection and fault record writer for type and translation faults
// assumes detect inputs come from same-clock translation and execute logic
`timescale 1ns/1ps
`include "tvf_consts.svh"
module tvf_fault_unit
  import tvf_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic checkValid, // execute check strobe
  input wire logic typeMismatch, // descriptor type wrong
  input wire logic contentsBad, // segment contents bad
  input wire logic xlateValid, // translation walk strobe
  input wire logic segDescValid, // segment descriptor valid flag
  input wire logic dirEntValid, // page_directory_entry valid flag
  input wire logic pageEntValid, // page_table_entry_item valid flag
  input wire logic largeSeg, // large-segment table in use
  input wire logic [31:0] faultAddr, // address faulted on
  input wire logic [26:0] segIndex, // segment index
  input wire logic [31:0] instIp, // faulting instruction IP
  input wire logic canSuspend, // instruction supports suspend
  input wire logic dispatchAck, // dispatch took record
  output logic busy, // record being built or awaiting dispatch ack
  output logic dispatchReq, // handler dispatch request
  output logic [7:0] faultType, // fault type code
  output logic [7:0] faultSubtype, // fault subtype code
  output logic [31:0] faultData0, // fault data word 0
  output logic [31:0] faultData1, // fault data word 1
  output logic [31:0] faultIp, // faulting instruction IP field
  output logic [31:0] savedIp, // saved IP
  output logic savedIpValid, // saved IP provided
  output logic restartable, // return to fault point allowed
  output logic suspended, // instruction suspended, resume pending
  output logic stateUndefined // process state undefined
);
  // ------------------------------------------------------------
  // detection
  // ------------------------------------------------------------
  logic typeHit;
  logic vmHit;
  logic [7:0] subNext;
  logic [31:0] d0Next;
  logic [31:0] d1Next;
  always_comb begin
    typeHit = checkValid && (typeMismatch || contentsBad);
    vmHit = xlateValid && (!segDescValid || !dirEntValid || !pageEntValid);
    subNext = 8'h00;
    d0Next = 32'h0;
    d1Next = 32'h0;
    if (vmHit) begin
      if (!segDescValid) begin
        subNext = `TVF_SUB_SEGENT;
        d1Next = {segIndex, 5'h00};
      end else if (!dirEntValid) begin
        subNext = `TVF_SUB_DIRENT;
        d0Next = {faultAddr[31:`TVF_ADDR_HI_LSB], 12'h000};
      end else begin
        subNext = `TVF_SUB_PAGEENT;
        d0Next = {faultAddr[31:`TVF_ADDR_HI_LSB], 12'h000};
        if (largeSeg) begin
          d1Next = {segIndex, 5'h00};
        end
      end
    end else if (typeHit) begin
      subNext = typeMismatch ? `TVF_SUB_MISMATCH : `TVF_SUB_CONTENTS;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  tvf_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] type_reg, type_next, sub_reg, sub_next;
  logic [31:0] d0_reg, d0_next, d1_reg, d1_next, ip_reg, ip_next;
  logic isVm_reg, isVm_next, susp_reg, susp_next;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    type_next = type_reg;
    sub_next = sub_reg;
    d0_next = d0_reg;
    d1_next = d1_reg;
    ip_next = ip_reg;
    isVm_next = isVm_reg;
    susp_next = susp_reg;
    case (state_reg)
      TVF_IDLE: begin
        if (vmHit || typeHit) begin
          type_next = vmHit ? `TVF_TYPE_VMFLT : `TVF_TYPE_TYPEFLT;
          sub_next = subNext;
          d0_next = d0Next;
          d1_next = d1Next;
          ip_next = instIp;
          isVm_next = vmHit;
          susp_next = vmHit && canSuspend;
          cnt_next = 3'h0;
          state_next = TVF_WRITE;
        end
      end
      TVF_WRITE: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == `TVF_WRITE_WORDS - 3'h1) begin
          state_next = TVF_DISPATCH;
        end
      end
      TVF_DISPATCH: begin
        if (dispatchAck) begin
          state_next = TVF_IDLE;
        end
      end
      default: state_next = TVF_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= TVF_IDLE;
      cnt_reg <= 3'h0;
      type_reg <= 8'h00;
      sub_reg <= 8'h00;
      d0_reg <= 32'h0;
      d1_reg <= 32'h0;
      ip_reg <= 32'h0;
      isVm_reg <= 1'b0;
      susp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      type_reg <= type_next;
      sub_reg <= sub_next;
      d0_reg <= d0_next;
      d1_reg <= d1_next;
      ip_reg <= ip_next;
      isVm_reg <= isVm_next;
      susp_reg <= susp_next;
    end
  end

  // ------------------------------------------------------------
  // record words, one written per cycle
  // ------------------------------------------------------------
  logic inWrite;
  logic [31:0] typeWord;
  logic [31:0] typeWordOut;
  assign inWrite = (state_reg == TVF_WRITE);
  assign typeWord = {16'h0000, type_reg, sub_reg};
  tvf_record_reg uTypeWord (.clk(clk), .srst(srst), .load(inWrite && cnt_reg == 3'h0),
    .dIn(typeWord), .dOut(typeWordOut));
  tvf_record_reg uData0 (.clk(clk), .srst(srst), .load(inWrite && cnt_reg == 3'h1),
    .dIn(d0_reg), .dOut(faultData0));
  tvf_record_reg uData1 (.clk(clk), .srst(srst), .load(inWrite && cnt_reg == 3'h2),
    .dIn(d1_reg), .dOut(faultData1));
  tvf_record_reg uFaultIp (.clk(clk), .srst(srst), .load(inWrite && cnt_reg == 3'h3),
    .dIn(ip_reg), .dOut(faultIp));
  tvf_record_reg uSavedIp (.clk(clk), .srst(srst), .load(inWrite && cnt_reg == 3'h4),
    .dIn(isVm_reg ? ip_reg : 32'h0), .dOut(savedIp));

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  logic [3:0] flags_reg, flags_next;
  always_comb begin
    flags_next = flags_reg;
    if (inWrite && cnt_reg == 3'h4) begin
      flags_next = {isVm_reg, isVm_reg, susp_reg, !isVm_reg};
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= 4'h0;
    end else begin
      flags_reg <= flags_next;
    end
  end
  assign faultType = typeWordOut[15:8];
  assign faultSubtype = typeWordOut[7:0];
  assign savedIpValid = flags_reg[3];
  assign restartable = flags_reg[2];
  assign suspended = flags_reg[1];
  assign stateUndefined = flags_reg[0];
  assign busy = (state_reg != TVF_IDLE);
  assign dispatchReq = (state_reg == TVF_DISPATCH);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_type_code: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && !isVm_reg |-> faultType == 8'h0a && (faultSubtype == 8'h01 || faultSubtype == 8'h02))
    else $error("type fault code wrong");
  a_mismatch_sub: assert property (@(posedge clk) disable iff (srst)
    !busy && !vmHit && checkValid && typeMismatch |-> ##6 faultSubtype == 8'h01)
    else $error("mismatch subtype wrong");
  a_contents_sub: assert property (@(posedge clk) disable iff (srst)
    !busy && !vmHit && checkValid && contentsBad && !typeMismatch |-> ##6 faultSubtype == 8'h02)
    else $error("contents subtype wrong");
  a_type_data: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && !isVm_reg |-> faultData0 == 32'h0 && faultData1 == 32'h0 && !savedIpValid)
    else $error("type fault data used");
  a_type_undef: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && !isVm_reg |-> stateUndefined && !restartable)
    else $error("type fault marked restartable");
  a_vm_code: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && isVm_reg |-> faultType == 8'h06)
    else $error("vm fault code wrong");
  a_seg_sub: assert property (@(posedge clk) disable iff (srst)
    !busy && xlateValid && !segDescValid |-> ##6 faultSubtype == 8'h01 && faultData1[31:5] == $past(segIndex, 6))
    else $error("segment fault record wrong");
  a_dir_sub: assert property (@(posedge clk) disable iff (srst)
    !busy && xlateValid && segDescValid && !dirEntValid |-> ##6 faultSubtype == 8'h02)
    else $error("directory subtype wrong");
  a_page_sub: assert property (@(posedge clk) disable iff (srst)
    !busy && xlateValid && segDescValid && dirEntValid && !pageEntValid |-> ##6 faultSubtype == 8'h03)
    else $error("page subtype wrong");
  a_addr_word: assert property (@(posedge clk) disable iff (srst)
    !busy && xlateValid && segDescValid && !dirEntValid |-> ##6 faultData0[31:12] == $past(faultAddr[31:12], 6))
    else $error("address word wrong");
  a_large_seg: assert property (@(posedge clk) disable iff (srst)
    !busy && xlateValid && segDescValid && dirEntValid && !pageEntValid && largeSeg
      |-> ##6 faultData1[31:5] == $past(segIndex, 6))
    else $error("large segment index wrong");
  a_saved_ip: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && isVm_reg |-> savedIp == faultIp && savedIpValid)
    else $error("saved ip mismatch");
  a_vm_restart: assert property (@(posedge clk) disable iff (srst)
    dispatchReq && isVm_reg |-> restartable && !stateUndefined)
    else $error("vm fault not restartable");
  a_suspend_sel: assert property (@(posedge clk) disable iff (srst)
    !busy && vmHit |-> ##6 suspended == $past(canSuspend, 6))
    else $error("suspend choice wrong");
  a_record_first: assert property (@(posedge clk) disable iff (srst)
    !busy && (vmHit || typeHit) |-> !dispatchReq [*6] ##1 dispatchReq)
    else $error("dispatch before record done");
  c_type_fault: cover property (@(posedge clk) disable iff (srst) dispatchReq && !isVm_reg);
  c_seg_fault: cover property (@(posedge clk) disable iff (srst) dispatchReq && isVm_reg && faultSubtype == 8'h01);
  c_page_large: cover property (@(posedge clk) disable iff (srst) dispatchReq && faultSubtype == 8'h03 && largeSeg);
  c_suspend: cover property (@(posedge clk) disable iff (srst) dispatchReq && suspended);
endmodule // tvf_fault_unit

//--- sim/tvf_dispatch_model.sv
// fault dispatch stand-in: takes the record after a chosen wait
// assumes the same clock and sync reset as the fault unit
`timescale 1ns/1ps
module tvf_dispatch_model (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic dispatchReq, // record ready
  input wire logic [3:0] ackDelay, // wait cycles before ack
  output logic dispatchAck // one-cycle take pulse
);
  logic [3:0] waitCnt_reg;
  // one-cycle ack while the request stands, prompt or slow
  always @(posedge clk) begin
    if (srst || !dispatchReq || dispatchAck) begin
      waitCnt_reg <= 4'h0;
      dispatchAck <= 1'b0;
    end else if (waitCnt_reg >= ackDelay) begin
      dispatchAck <= 1'b1;
    end else begin
      waitCnt_reg <= waitCnt_reg + 4'h1;
    end
  end
endmodule // tvf_dispatch_model

//--- sim/test_type_and_vm_fault_reporting.sv
// self-checking bench for the fault unit with a dispatch stand-in
// assumes inputs change on the falling edge only
`timescale 1ns/1ps
module test_type_and_vm_fault_reporting;
  import tvf_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic checkValid, typeMismatch, contentsBad, xlateValid, segDescValid, dirEntValid, pageEntValid;
  logic largeSeg, canSuspend, dispatchAck, busy, dispatchReq;
  logic savedIpValid, restartable, suspended, stateUndefined;
  logic [31:0] faultAddr, instIp, faultData0, faultData1, faultIp, savedIp;
  logic [26:0] segIndex;
  logic [3:0] ackDelay;
  logic [7:0] faultType, faultSubtype;
  int numErrors = 0;
  int comparisons = 0;

  // ----------------------------------------
  // clock, design and dispatch side
  // ----------------------------------------
  always #2.5 clk = ~clk;
  tvf_fault_unit tvf_fault_unit_i (.clk, .srst, .checkValid, .typeMismatch, .contentsBad, .xlateValid,
    .segDescValid, .dirEntValid, .pageEntValid, .largeSeg, .faultAddr, .segIndex, .instIp, .canSuspend,
    .dispatchAck, .busy, .dispatchReq, .faultType, .faultSubtype, .faultData0, .faultData1, .faultIp,
    .savedIp, .savedIpValid, .restartable, .suspended, .stateUndefined);
  tvf_dispatch_model tvf_dispatch_model_i (.clk, .srst, .dispatchReq, .ackDelay, .dispatchAck);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tmo(input string what);
    cmp(what, 32'h1, 32'h0);
    wrap_up();
  endtask

  // detect order: check, mismatch, contents, walk, seg, dir, page flags
  task automatic set_det(input logic [6:0] d);
    {checkValid, typeMismatch, contentsBad, xlateValid, segDescValid, dirEntValid, pageEntValid} = d;
  endtask

  task automatic chk_rec(input logic [7:0] ty, sub, input logic [31:0] d0, d1, fip, sip, input logic [3:0] fl);
    cmp("faultType", {24'h0, ty}, {24'h0, faultType});
    cmp("faultSubtype", {24'h0, sub}, {24'h0, faultSubtype});
    cmp("faultData0", d0, faultData0);
    cmp("faultData1", d1, faultData1);
    cmp("faultIp", fip, faultIp);
    cmp("savedIp", sip, savedIp);
    cmp("flags", {28'h0, fl}, {28'h0, savedIpValid, restartable, suspended, stateUndefined});
  endtask

  // present one detection, optionally a refused one while busy, wait for request
  task automatic fire(input logic [6:0] det, input logic [3:0] dly, input bit inject);
    int n = 0;
    ackDelay = dly;
    set_det(det);
    @(negedge clk);
    set_det(7'b0000111);
    cmp("busy", 32'h1, {31'h0, busy});
    while (dispatchReq !== 1'b1) begin
      if (inject && n == 0) begin
        set_det(7'b1101000);
        instIp = 32'hffff0000;
        faultAddr = ~faultAddr;
        segIndex = ~segIndex;
      end else set_det(7'b0000111);
      n++;
      if (n > 10) tmo("dispatchReq");
      @(negedge clk);
    end
  endtask

  // request must stand until the ack, then busy drops
  task automatic done();
    int n = 0;
    while (busy !== 1'b0) begin
      cmp("dispatchReq", 32'h1, {31'h0, dispatchReq});
      n++;
      if (n > 20) tmo("busy");
      @(negedge clk);
    end
    cmp("dispatchReq", 32'h0, {31'h0, dispatchReq});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_rec(8'h00, 8'h00, 32'h0, 32'h0, 32'h0, 32'h0, 4'h0);
    cmp("busy", 32'h0, {31'h0, busy});
    $display("test reset done");
  endtask

  task automatic t_type();
    faultAddr = 32'h89abcdef;
    instIp = 32'h00001234;
    canSuspend = 1'b1;
    largeSeg = 1'b1;
    fire(7'b1110111, 4'h0, 1'b0);
    chk_rec(8'h0a, 8'h01, 32'h0, 32'h0, 32'h00001234, 32'h0, 4'b0001);
    done();
    instIp = 32'h00005678;
    fire(7'b1010111, 4'h5, 1'b0);
    chk_rec(8'h0a, 8'h02, 32'h0, 32'h0, 32'h00005678, 32'h0, 4'b0001);
    done();
    $display("test type faults done");
  endtask

  task automatic t_seg();
    faultAddr = 32'h89abcdef;
    segIndex = 27'h5a5a5a5;
    instIp = 32'h0000abcd;
    canSuspend = 1'b1;
    fire(7'b1101000, 4'h2, 1'b1);
    chk_rec(8'h06, 8'h01, 32'h0, 32'hb4b4b4a0, 32'habcd, 32'habcd, 4'b1110);
    done();
    $display("test segment fault done");
  endtask

  task automatic t_dir_page();
    faultAddr = 32'h12345678;
    instIp = 32'h00002000;
    canSuspend = 1'b0;
    largeSeg = 1'b1;
    fire(7'b0001100, 4'h1, 1'b0);
    chk_rec(8'h06, 8'h02, 32'h12345000, 32'h0, 32'h00002000, 32'h00002000, 4'b1100);
    done();
    largeSeg = 1'b0;
    faultAddr = 32'hfedcb987;
    fire(7'b0001110, 4'h0, 1'b0);
    chk_rec(8'h06, 8'h03, 32'hfedcb000, 32'h0, 32'h00002000, 32'h00002000, 4'b1100);
    done();
    largeSeg = 1'b1;
    segIndex = 27'h7ffffff;
    faultAddr = 32'h00000fff;
    fire(7'b0001110, 4'h3, 1'b0);
    chk_rec(8'h06, 8'h03, 32'h0, 32'hffffffe0, 32'h00002000, 32'h00002000, 4'b1100);
    done();
    $display("test directory and page faults done");
  endtask

  // reset in the middle of a record, then a fault on the first edge after release
  task automatic t_midreset();
    instIp = 32'h00003000;
    set_det(7'b1100111);
    @(negedge clk);
    set_det(7'b0000111);
    repeat (2) @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk_rec(8'h00, 8'h00, 32'h0, 32'h0, 32'h0, 32'h0, 4'h0);
    cmp("busy", 32'h0, {31'h0, busy});
    fire(7'b1010111, 4'h0, 1'b0);
    chk_rec(8'h0a, 8'h02, 32'h0, 32'h0, 32'h00003000, 32'h0, 4'b0001);
    done();
    $display("test mid-run reset done");
  endtask

  task automatic t_clean();
    set_det(7'b1001111);
    @(negedge clk);
    set_det(7'b0000111);
    repeat (3) @(negedge clk);
    cmp("busy", 32'h0, {31'h0, busy});
    cmp("dispatchReq", 32'h0, {31'h0, dispatchReq});
    $display("test no fault done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    set_det(7'b0000111);
    largeSeg = 1'b0;
    canSuspend = 1'b0;
    faultAddr = 32'h0;
    instIp = 32'h0;
    segIndex = 27'h0;
    ackDelay = 4'h0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_type();
    t_seg();
    t_dir_page();
    t_midreset();
    t_clean();
    wrap_up();
  end
endmodule // test_type_and_vm_fault_reporting
